// ==== sram_tap.sv ====
// Test access port of the synchronous memory
`timescale 1ns/100ps
`default_nettype none
`include "sram_tap_map.svh"

module sram_tap #(
  // Arbitrary identification value; bit 0 must stay one
  parameter logic [`TAP_ID_W-1:0] IDENT_VALUE = 32'h0000_0001,
  parameter int                   CHAIN_W     = `TAP_CHAIN_W
) (
  // Memory clock and power-up reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Serial test link
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdo_oe,
  // Memory balls, test clock side
  input  wire logic [CHAIN_W-1:0]  pad_in,
  output logic [CHAIN_W-1:0]       pad_drive_q,
  output logic                     pad_drive_en,
  output logic                     pad_float,
  // Test modes seen by the memory core
  output logic                     mem_ext_drive,
  output logic                     mem_out_float
);
  import sram_tap_pkg::*;

  if (CHAIN_W != `TAP_CHAIN_W) begin : g_bad_chain
    $error("boundary chain length must match the ball map");
  end
  if (IDENT_VALUE[0] != 1'b1) begin : g_bad_ident
    $error("identification value must end in a one");
  end

  // Power-up reset carried onto the test clock
  logic       por_n;
  logic       prst;

  // Controller state
  tap_state_t st_q;
  tap_state_t st_d;
  tap_instr_t instr_q;

  // Serial registers
  logic [`TAP_IR_W-1:0]     ir_sr;
  logic [`TAP_BYPASS_W-1:0] byp_sr;
  logic [`TAP_ID_W-1:0]     id_sr;
  logic [CHAIN_W-1:0]       chain_sr;
  logic                     ir_so;
  logic                     byp_so;
  logic                     id_so;
  logic                     chain_so;
  logic                     sel_byp;
  logic                     sel_id;
  logic                     sel_chain;
  logic                     dr_so;
  logic                     so_mux;

  // Mode levels in the test clock domain
  logic ext_drive_q;
  logic float_q;

  scan_ctl_if ir_ctl ();
  scan_ctl_if dr_ctl ();

  level_sync #(
    .RST_VAL (1'b0)
  ) u_por_sync (
    .clk   (tck),
    .rst_n (1'b1),
    .d     (rstn),
    .q     (por_n)
  );

  assign prst = !por_n;

  // Next controller state from mode select
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_RESET:      st_d = tms ? ST_RESET     : ST_IDLE;
      ST_IDLE:       st_d = tms ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_DR:  st_d = tms ? ST_SELECT_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: st_d = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_SHIFT_DR:   st_d = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
      ST_EXIT1_DR:   st_d = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   st_d = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
      ST_EXIT2_DR:   st_d = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  st_d = tms ? ST_SELECT_DR : ST_IDLE;
      ST_SELECT_IR:  st_d = tms ? ST_RESET     : ST_CAPTURE_IR;
      ST_CAPTURE_IR: st_d = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_SHIFT_IR:   st_d = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
      ST_EXIT1_IR:   st_d = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   st_d = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
      ST_EXIT2_IR:   st_d = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  st_d = tms ? ST_SELECT_DR : ST_IDLE;
    endcase
  end

  // Controller advances on every rising test clock edge
  always_ff @(posedge tck) begin
    if (prst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Path strobes
  assign ir_ctl.capture = (st_q == ST_CAPTURE_IR);
  assign ir_ctl.shift   = (st_q == ST_SHIFT_IR);
  assign ir_ctl.si      = tdi;
  assign dr_ctl.capture = (st_q == ST_CAPTURE_DR);
  assign dr_ctl.shift   = (st_q == ST_SHIFT_DR);
  assign dr_ctl.si      = tdi;

  // Data register selection; reserved codes fall back to bypass
  always_comb begin
    sel_byp   = 1'b0;
    sel_id    = 1'b0;
    sel_chain = 1'b0;
    unique case (instr_q)
      OP_EXTEST:  sel_chain = 1'b1;
      OP_IDCODE:  sel_id    = 1'b1;
      OP_SAMPLEZ: sel_chain = 1'b1;
      OP_SAMPLE:  sel_chain = 1'b1;
      OP_BYPASS:  sel_byp   = 1'b1;
      OP_RSVD3,
      OP_RSVD5,
      OP_RSVD6:   sel_byp   = 1'b1;
    endcase
  end

  // Serial registers
  scan_reg #(
    .W (`TAP_IR_W)
  ) u_ir (
    .tck     (tck),
    .ctl     (ir_ctl),
    .sel     (1'b1),
    .cap_val (`TAP_IR_CAPTURE),
    .sr_q    (ir_sr),
    .so      (ir_so)
  );

  scan_reg #(
    .W (`TAP_BYPASS_W)
  ) u_byp (
    .tck     (tck),
    .ctl     (dr_ctl),
    .sel     (sel_byp),
    .cap_val (`TAP_BYPASS_CAPTURE),
    .sr_q    (byp_sr),
    .so      (byp_so)
  );

  scan_reg #(
    .W (`TAP_ID_W)
  ) u_id (
    .tck     (tck),
    .ctl     (dr_ctl),
    .sel     (sel_id),
    .cap_val (IDENT_VALUE),
    .sr_q    (id_sr),
    .so      (id_so)
  );

  // Balls are sampled straight on the test clock; a ball in transition
  // may settle either way, which the capture tolerates
  scan_reg #(
    .W (CHAIN_W)
  ) u_chain (
    .tck     (tck),
    .ctl     (dr_ctl),
    .sel     (sel_chain),
    .cap_val (pad_in),
    .sr_q    (chain_sr),
    .so      (chain_so)
  );

  // Active instruction, loaded at Update-IR
  always_ff @(posedge tck) begin
    if (prst || st_q == ST_RESET) begin
      instr_q <= OP_IDCODE;
    end else if (st_q == ST_UPDATE_IR) begin
      instr_q <= tap_instr_t'(ir_sr);
    end
  end

  // Output drive and float modes follow the instruction update
  always_ff @(posedge tck) begin
    if (prst || st_q == ST_RESET) begin
      ext_drive_q <= 1'b0;
      float_q     <= 1'b0;
    end else if (st_q == ST_UPDATE_IR) begin
      ext_drive_q <= (ir_sr == `TAP_OP_EXTEST);
      float_q     <= (ir_sr == `TAP_OP_SAMPLEZ);
    end
  end

  // Held output values, updated from the chain by preload or external test
  always_ff @(posedge tck) begin
    if (prst) begin
      pad_drive_q <= '0;
    end else if (st_q == ST_UPDATE_DR &&
                 (instr_q == OP_SAMPLE || instr_q == OP_EXTEST)) begin
      pad_drive_q <= chain_sr;
    end
  end

  assign pad_drive_en = ext_drive_q;
  assign pad_float    = float_q;

  // Serial output selection
  always_comb begin
    if (sel_id) begin
      dr_so = id_so;
    end else if (sel_chain) begin
      dr_so = chain_so;
    end else begin
      dr_so = byp_so;
    end
  end

  assign so_mux = (st_q == ST_SHIFT_IR) ? ir_so : dr_so;

  // Serial output changes on the falling test clock edge
  always_ff @(negedge tck) begin
    if (prst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo    <= so_mux;
      tdo_oe <= (st_q == ST_SHIFT_IR) || (st_q == ST_SHIFT_DR);
    end
  end

  // Modes carried to the memory clock domain
  level_sync #(
    .RST_VAL (1'b0)
  ) u_drive_sync (
    .clk   (sys_clk),
    .rst_n (rstn),
    .d     (ext_drive_q),
    .q     (mem_ext_drive)
  );

  level_sync #(
    .RST_VAL (1'b0)
  ) u_float_sync (
    .clk   (sys_clk),
    .rst_n (rstn),
    .d     (float_q),
    .q     (mem_out_float)
  );

  // Checks

  AST_TMS_RESET: assert property (
    @(posedge tck) disable iff (prst)
    tms [*5] |=> (st_q == ST_RESET))
    else $error("five high mode selects did not reach reset");

  AST_IDCODE_DEFAULT: assert property (
    @(posedge tck) disable iff (prst)
    (st_q == ST_RESET) |=> (instr_q == OP_IDCODE))
    else $error("identify not active after reset state");

  AST_IDENT_CAPTURE: assert property (
    @(posedge tck) disable iff (prst)
    (st_q == ST_CAPTURE_DR && instr_q == OP_IDCODE)
      |=> (id_sr == IDENT_VALUE))
    else $error("identification value not captured");

  AST_IDENT_SHIFT: assert property (
    @(posedge tck) disable iff (prst)
    (st_q == ST_SHIFT_DR && instr_q == OP_IDCODE)
      |=> (id_sr[`TAP_ID_W-1] == $past(tdi)))
    else $error("identification register not in serial path");

  AST_BYPASS_ONE: assert property (
    @(posedge tck) disable iff (prst)
    (st_q == ST_SHIFT_DR && instr_q == OP_BYPASS)
      |=> (byp_sr[0] == $past(tdi)) ##1 (st_q != ST_SHIFT_DR ||
          byp_sr[0] == $past(tdi)))
    else $error("bypass path is not one stage");

  AST_EXTEST_ON: assert property (
    @(posedge tck) disable iff (prst)
    (st_q == ST_UPDATE_IR && ir_sr == `TAP_OP_EXTEST)
      |=> pad_drive_en && $stable(pad_drive_q))
    else $error("external test did not drive preloaded values");

  AST_FLOAT_HOLD: assert property (
    @(posedge tck) disable iff (prst)
    (instr_q == OP_SAMPLEZ) |-> pad_float && !pad_drive_en)
    else $error("outputs not floated under floated sample");

  AST_CHAIN_CAPTURE: assert property (
    @(posedge tck) disable iff (prst)
    (st_q == ST_CAPTURE_DR && sel_chain) |=> (chain_sr == $past(pad_in)))
    else $error("boundary chain did not capture ball values");

  AST_RESERVED_INERT: assert property (
    @(posedge tck) disable iff (prst)
    (instr_q == OP_RSVD3 || instr_q == OP_RSVD5 || instr_q == OP_RSVD6)
      |-> !pad_drive_en && !pad_float && sel_byp)
    else $error("reserved code changed device behaviour");

  AST_TDO_FALL: assert property (
    @(negedge tck) disable iff (prst)
    (st_q == ST_SHIFT_DR) |=> (tdo == $past(so_mux)) && tdo_oe)
    else $error("serial output not updated on falling edge");

  AST_MEM_DRIVE: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    mem_out_float |-> !mem_ext_drive)
    else $error("memory driven while outputs floated");
endmodule

`default_nettype wire

// ==== sram_tap_map.svh ====
// Constants of the memory test access port: lengths, codes and counts
`ifndef SRAM_TAP_MAP_SVH
`define SRAM_TAP_MAP_SVH

// Register lengths
`define TAP_IR_W          3
`define TAP_BYPASS_W      1
`define TAP_ID_W          32
`define TAP_CHAIN_W       109

// Instruction codes
`define TAP_OP_EXTEST     3'h0
`define TAP_OP_IDCODE     3'h1
`define TAP_OP_SAMPLEZ    3'h2
`define TAP_OP_RSVD3      3'h3
`define TAP_OP_SAMPLE     3'h4
`define TAP_OP_RSVD5      3'h5
`define TAP_OP_RSVD6      3'h6
`define TAP_OP_BYPASS     3'h7

// Fixed pattern loaded into the instruction shifter at Capture-IR
`define TAP_IR_CAPTURE    3'h1
// Value loaded into the bypass stage at Capture-DR
`define TAP_BYPASS_CAPTURE 1'h0

// Rising test clock edges with mode select high that force reset
`define TAP_RESET_EDGES   5
// Stages in a level synchroniser
`define TAP_SYNC_STAGES   3

`endif

// ==== sram_tap_pkg.sv ====
// Types of the memory test access port
`include "sram_tap_map.svh"

package sram_tap_pkg;

  typedef enum logic [3:0] {
    ST_EXIT2_DR   = 4'b0000,
    ST_EXIT1_DR   = 4'b0001,
    ST_SHIFT_DR   = 4'b0010,
    ST_PAUSE_DR   = 4'b0011,
    ST_SELECT_IR  = 4'b0100,
    ST_UPDATE_DR  = 4'b0101,
    ST_CAPTURE_DR = 4'b0110,
    ST_SELECT_DR  = 4'b0111,
    ST_EXIT2_IR   = 4'b1000,
    ST_EXIT1_IR   = 4'b1001,
    ST_SHIFT_IR   = 4'b1010,
    ST_PAUSE_IR   = 4'b1011,
    ST_IDLE       = 4'b1100,
    ST_UPDATE_IR  = 4'b1101,
    ST_CAPTURE_IR = 4'b1110,
    ST_RESET      = 4'b1111
  } tap_state_t;

  typedef enum logic [`TAP_IR_W-1:0] {
    OP_EXTEST  = `TAP_OP_EXTEST,
    OP_IDCODE  = `TAP_OP_IDCODE,
    OP_SAMPLEZ = `TAP_OP_SAMPLEZ,
    OP_RSVD3   = `TAP_OP_RSVD3,
    OP_SAMPLE  = `TAP_OP_SAMPLE,
    OP_RSVD5   = `TAP_OP_RSVD5,
    OP_RSVD6   = `TAP_OP_RSVD6,
    OP_BYPASS  = `TAP_OP_BYPASS
  } tap_instr_t;

endpackage

// ==== scan_ctl_if.sv ====
// Capture and shift strobes shared by the serial registers of one path
`timescale 1ns/100ps
`default_nettype none

interface scan_ctl_if;
  logic capture;
  logic shift;
  logic si;

  modport src  (output capture, output shift, output si);
  modport sink (input capture, input shift, input si);
endinterface

`default_nettype wire

// ==== level_sync.sv ====
// Three-stage level synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
`include "sram_tap_map.svh"

module level_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset of the receiving domain
  input  wire logic clk,
  input  wire logic rst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);
  logic [`TAP_SYNC_STAGES-1:0] st_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= {`TAP_SYNC_STAGES{RST_VAL}};
    end else begin
      st_q <= {st_q[`TAP_SYNC_STAGES-2:0], d};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else if (st_q[1] == st_q[2]) begin
      q <= st_q[2];
    end
  end
endmodule

`default_nettype wire

// ==== scan_reg.sv ====
// One serial test register: parallel capture, shift toward the output bit
`timescale 1ns/100ps
`default_nettype none

module scan_reg #(
  parameter int W = 1
) (
  // Test clock
  input  wire logic        tck,
  // Path strobes and selection
  scan_ctl_if.sink         ctl,
  input  wire logic        sel,
  input  wire logic [W-1:0] cap_val,
  // Contents
  output logic [W-1:0]     sr_q,
  output logic             so
);
  logic [W-1:0] shift_d;

  if (W < 1) begin : g_bad_width
    $error("scan_reg width must be at least one");
  end

  if (W == 1) begin : g_one
    assign shift_d = ctl.si;
  end else begin : g_many
    assign shift_d = {ctl.si, sr_q[W-1:1]};
  end

  always_ff @(posedge tck) begin
    if (sel && ctl.capture) begin
      sr_q <= cap_val;
    end else if (sel && ctl.shift) begin
      sr_q <= shift_d;
    end
  end

  assign so = sr_q[0];
endmodule

`default_nettype wire

// ==== scan_master_model.sv ====
// Board scan controller model driving the serial test link
`timescale 1ns/100ps
`default_nettype none

module scan_master_model (
  // Serial test link
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock period; mode and data change while tck is low
  task automatic step(input logic m, input logic d, output logic o,
                      output logic oe);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    o = tdo;
    oe = tdo_oe;
    #62.5 tck = 1'b0;
  endtask

  // Outside shifting the data line toggles so no stale level is seen
  task automatic move(input logic m);
    logic o, oe;
    step(m, ~tdi, o, oe);
  endtask

  // Mode select held high for k edges
  task automatic tms_reset(input int k);
    repeat (k) move(1'b1);
  endtask

  // Register scan from Idle back to Idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout, output logic oe_all);
    logic o, oe;
    dout = '0;
    oe_all = 1'b1;
    #3.3;
    move(1'b1);
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, oe);
      dout[i] = o;
      oe_all = oe_all & oe;
    end
    move(1'b1);
    move(1'b0);
  endtask
endmodule

`default_nettype wire

// ==== sram_tap_tb.sv ====
// Self-checking bench of the memory test access port
`timescale 1ns/100ps
`default_nettype none
`include "sram_tap_map.svh"

module sram_tap_tb;
  // Arbitrary identification value, bit 0 set
  localparam logic [31:0] ID = 32'h5a3c_96e1;
  localparam int          CW = `TAP_CHAIN_W;
  localparam int          N  = 120;

  logic          sys_clk = 1'b0;
  logic          rstn;
  logic          tck, tms, tdi, tdo, tdo_oe;
  logic [CW-1:0] pad_in, pad_drive_q, pre;
  logic          pad_drive_en, pad_float, mem_ext_drive, mem_out_float;
  logic [127:0]  din, dout, cap;
  logic          oe;
  logic [2:0]    op;
  logic [2:0]    codes [8] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6,
                               3'h7};
  int            failures = 0;
  int            tests_run = 0;
  int            seed = 32'h375f384c;
  int            len;

  always #12.5 sys_clk = ~sys_clk;

  sram_tap #(.IDENT_VALUE(ID), .CHAIN_W(CW)) i_sram_tap (
    .sys_clk(sys_clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in),
    .pad_drive_q(pad_drive_q), .pad_drive_en(pad_drive_en),
    .pad_float(pad_float), .mem_ext_drive(mem_ext_drive),
    .mem_out_float(mem_out_float));

  scan_master_model i_scan_master_model (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

  task automatic chk_scan(input logic [127:0] got, input logic [127:0] ex);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %0t scan got %h exp %h", $time, got, ex);
    end
  endtask

  task automatic chk_pad(input logic [CW-1:0] got, input logic [CW-1:0] ex);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %0t pads got %h exp %h", $time, got, ex);
    end
  endtask

  task automatic chk_bit(input logic got, input logic ex);
    tests_run++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %0t flag got %h exp %h", $time, got, ex);
    end
  endtask

  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction

  // Expected serial output: captured bits first, then the shifted input
  function automatic logic [127:0] model(input int l, input logic [127:0] c,
                                         input logic [127:0] d);
    logic q [$];
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < l; i++) q.push_back(c[i]);
    for (int i = 0; i < N; i++) q.push_back(d[i]);
    for (int i = 0; i < N; i++) r[i] = q.pop_front();
    return r;
  endfunction

  task automatic do_reset();
    rstn = 1'b0;
    i_scan_master_model.tms_reset(8);
    @(negedge sys_clk);
    rstn = 1'b1;
    i_scan_master_model.tms_reset(6);
    i_scan_master_model.move(1'b0);
  endtask

  task automatic ident_check();
    din = rnd();
    i_scan_master_model.scan(1'b0, N, din, dout, oe);
    chk_scan(dout, model(32, {96'h0, ID}, din));
    chk_bit(pad_drive_en, 1'b0);
    chk_bit(pad_float, 1'b0);
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    failures++;
    end_sim();
  end

  initial begin
    rstn = 1'b0;
    pad_in = '0;
    #1;
    do_reset();
    ident_check();
    $display("test power_up_ident done");
    foreach (codes[k]) begin
      op = codes[k];
      i_scan_master_model.scan(1'b1, 3, {125'h0, op}, dout, oe);
      chk_scan(dout, {125'h0, `TAP_IR_CAPTURE});
      chk_bit(oe, 1'b1);
      chk_bit(pad_drive_en, op == `TAP_OP_EXTEST);
      chk_bit(pad_float, op == `TAP_OP_SAMPLEZ);
      if (op == `TAP_OP_EXTEST) chk_pad(pad_drive_q, pre);
      @(negedge sys_clk);
      din = rnd();
      pad_in = din[CW-1:0];
      case (op)
        `TAP_OP_EXTEST, `TAP_OP_SAMPLEZ, `TAP_OP_SAMPLE: len = CW;
        `TAP_OP_IDCODE: len = 32;
        default: len = 1;
      endcase
      cap = (len == CW) ? {19'h0, pad_in} : (len == 32) ? {96'h0, ID} :
            {127'h0, `TAP_BYPASS_CAPTURE};
      din = rnd();
      i_scan_master_model.scan(1'b0, N, din, dout, oe);
      chk_scan(dout, model(len, cap, din));
      chk_bit(oe, 1'b1);
      if (op == `TAP_OP_SAMPLE || op == `TAP_OP_EXTEST) begin
        pre = din[N-1 -: CW];
        chk_pad(pad_drive_q, pre);
      end
      repeat (8) @(negedge sys_clk);
      chk_bit(mem_ext_drive, op == `TAP_OP_EXTEST);
      chk_bit(mem_out_float, op == `TAP_OP_SAMPLEZ);
      chk_bit(tdo_oe, 1'b0);
      // Clock recovery cycles before the memory is used again
      if (op == `TAP_OP_SAMPLEZ) repeat (16) @(negedge sys_clk);
      $display("test code %0d done", op);
    end
    i_scan_master_model.scan(1'b1, 3, {125'h0, 3'h0}, dout, oe);
    chk_bit(pad_drive_en, 1'b1);
    i_scan_master_model.tms_reset(5);
    i_scan_master_model.move(1'b0);
    repeat (8) @(negedge sys_clk);
    chk_bit(mem_ext_drive, 1'b0);
    ident_check();
    $display("test mode_select_reset done");
    i_scan_master_model.scan(1'b1, 3, {125'h0, 3'h0}, dout, oe);
    do_reset();
    ident_check();
    $display("test second_reset done");
    end_sim();
  end
endmodule

`default_nettype wire
